/* File: rtl/dspp_source_pack.sv */
/*
 DMA channel source side: source port select, element reads and packing
 into port words, pushed through a FIFO to the channel stream output.
 Assumes AXI4-Lite master for registers and source ports on the same clock.
*/
`timescale 1ns/10ps
`default_nettype none
`include "dspp_defines.svh"
module dspp_source_pack (
    input wire logic clock,
    input wire logic reset,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    output logic [1:0] s_axi_bresp,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    input wire logic [7:0] s_axi_araddr,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output dspp_pkg::dspp_req_t srcReq,
    output logic srcReqValid,
    input wire logic srcReqReady,
    input wire logic srcRspValid,
    input wire logic [31:0] srcRspData,
    output dspp_pkg::dspp_word_t outWord,
    output logic outValid,
    input wire logic outReady
);
    logic awHeld_q, awHeld_d, awReady_q;
    logic wHeld_q, wHeld_d, wReady_q;
    logic [7:0] awAddr_q;
    logic [31:0] wData_q;
    logic [3:0] wStrb_q;
    logic bValid_q, rValid_q, rValid_d, arReady_q;
    logic [1:0] bResp_q, rResp_q;
    logic [31:0] rData_q, rdMux;
    logic rdHit, wrHit, doWrite;
    logic [15:0] params_q, srcAddrReg_q, count_q;
    logic done_q, cfgErr_q, protErr_q;
    dspp_pkg::dspp_state_t state_q;
    dspp_pkg::dspp_src_t srcSel_q;
    dspp_pkg::dspp_dtype_t dtype_q;
    logic [15:0] addr_q, remain_q;
    logic packActive_q;
    logic [2:0] portBytes_q, elemBytes_q, packBytes_q, fill_q;
    logic [31:0] acc_q;
    dspp_pkg::dspp_req_t req_q;
    logic reqValid_q;
    dspp_pkg::dspp_word_t pushWord_q, fifoOut;
    logic pushValid_q, fifoInReady, fifoOutValid, fifoPop;
    dspp_pkg::dspp_word_t outWord_q;
    logic outValid_q;
    logic startPulse, startOk, startBad, protHit, lastDone;
    logic [3:0] cfgSrc;
    logic [1:0] cfgDt;
    logic [2:0] cfgPort, cfgElem, newFill;
    logic [31:0] elemMask, accNext;

    function automatic logic [15:0] strb16(input logic [15:0] old, input logic [31:0] d, input logic [3:0] s);
        strb16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
    endfunction : strb16

    ////////////////////////////////////////////////////////////////////////
    // AXI4-Lite write channel, address and data taken in either order
    assign awHeld_d = (s_axi_awvalid && awReady_q) ? 1'b1 : (doWrite ? 1'b0 : awHeld_q);
    assign wHeld_d = (s_axi_wvalid && wReady_q) ? 1'b1 : (doWrite ? 1'b0 : wHeld_q);
    assign doWrite = awHeld_q && wHeld_q && !bValid_q;
    assign wrHit = awAddr_q[7:2] inside {`DSPP_OFS_PARAMS >> 2, `DSPP_OFS_SRCADDR >> 2, `DSPP_OFS_COUNT >> 2,
        `DSPP_OFS_CTRL >> 2, `DSPP_OFS_STATUS >> 2};

    always_ff @(posedge clock) begin
        if (reset) begin
            awHeld_q <= 1'b0;
            wHeld_q <= 1'b0;
            awReady_q <= 1'b0;
            wReady_q <= 1'b0;
            awAddr_q <= 8'h00;
            wData_q <= 32'h00000000;
            wStrb_q <= 4'h0;
        end else begin
            awHeld_q <= awHeld_d;
            wHeld_q <= wHeld_d;
            awReady_q <= !awHeld_d;
            wReady_q <= !wHeld_d;
            if (s_axi_awvalid && awReady_q) begin
                awAddr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && wReady_q) begin
                wData_q <= s_axi_wdata;
                wStrb_q <= s_axi_wstrb;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            bValid_q <= 1'b0;
            bResp_q <= `DSPP_RESP_OKAY;
        end else if (doWrite) begin
            bValid_q <= 1'b1;
            bResp_q <= wrHit ? `DSPP_RESP_OKAY : `DSPP_RESP_SLVERR;
        end else if (s_axi_bready) begin
            bValid_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // AXI4-Lite read channel, answer one cycle after the address
    always_comb begin
        rdHit = 1'b1;
        rdMux = 32'h00000000;
        case ({s_axi_araddr[7:2], 2'b00})
            `DSPP_OFS_PARAMS: rdMux = {16'h0000, params_q};
            `DSPP_OFS_SRCADDR: rdMux = {16'h0000, srcAddrReg_q};
            `DSPP_OFS_COUNT: rdMux = {16'h0000, count_q};
            `DSPP_OFS_CTRL: rdMux = 32'h00000000;
            `DSPP_OFS_STATUS: rdMux = {remain_q, 12'h000, protErr_q, cfgErr_q, done_q, state_q != dspp_pkg::DSPP_IDLE};
            default: rdHit = 1'b0;
        endcase
    end

    assign rValid_d = (s_axi_arvalid && arReady_q) ? 1'b1 : (s_axi_rready ? 1'b0 : rValid_q);

    always_ff @(posedge clock) begin
        if (reset) begin
            rValid_q <= 1'b0;
            arReady_q <= 1'b0;
            rData_q <= 32'h00000000;
            rResp_q <= `DSPP_RESP_OKAY;
        end else begin
            rValid_q <= rValid_d;
            arReady_q <= !rValid_d;
            if (s_axi_arvalid && arReady_q) begin
                rData_q <= rdMux;
                rResp_q <= rdHit ? `DSPP_RESP_OKAY : `DSPP_RESP_SLVERR;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Configuration registers
    always_ff @(posedge clock) begin
        if (reset) begin
            params_q <= `DSPP_RST_PARAMS;
            srcAddrReg_q <= `DSPP_RST_SRCADDR;
            count_q <= `DSPP_RST_COUNT;
        end else if (doWrite) begin
            case ({awAddr_q[7:2], 2'b00})
                `DSPP_OFS_PARAMS: params_q <= strb16(params_q, wData_q, wStrb_q);
                `DSPP_OFS_SRCADDR: srcAddrReg_q <= strb16(srcAddrReg_q, wData_q, wStrb_q);
                `DSPP_OFS_COUNT: count_q <= strb16(count_q, wData_q, wStrb_q);
                default: ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Start checks and channel setup
    assign startPulse = doWrite && {awAddr_q[7:2], 2'b00} == `DSPP_OFS_CTRL && wStrb_q[0] && wData_q[`DSPP_CTRL_START];
    assign cfgSrc = params_q[`DSPP_SRC_MSB:`DSPP_SRC_LSB];
    assign cfgDt = params_q[`DSPP_DT_MSB:`DSPP_DT_LSB];
    // [RULE5] [RULE9] reject reserved or unsupported setups
    assign startBad = cfgSrc > dspp_pkg::DSPP_SRC_PERIPH || cfgDt > dspp_pkg::DSPP_DT_32
        || (cfgSrc == dspp_pkg::DSPP_SRC_PERIPH && cfgDt == dspp_pkg::DSPP_DT_8);
    assign startOk = startPulse && state_q == dspp_pkg::DSPP_IDLE && !startBad;
    assign cfgPort = cfgSrc == dspp_pkg::DSPP_SRC_PERIPH ? `DSPP_PERIPH_BYTES : `DSPP_MEM_BYTES;
    // [RULE11] element size from data type
    assign cfgElem = cfgDt == dspp_pkg::DSPP_DT_8 ? 3'h1 : (cfgDt == dspp_pkg::DSPP_DT_16 ? 3'h2 : 3'h4);

    always_ff @(posedge clock) begin
        if (reset) begin
            srcSel_q <= dspp_pkg::DSPP_SRC_SINGLE_RAM;
            dtype_q <= dspp_pkg::DSPP_DT_8;
            packActive_q <= 1'b0;
            portBytes_q <= `DSPP_MEM_BYTES;
            elemBytes_q <= 3'h1;
            packBytes_q <= 3'h1;
        end else if (startOk) begin
            srcSel_q <= dspp_pkg::dspp_src_t'(cfgSrc);
            dtype_q <= dspp_pkg::dspp_dtype_t'(cfgDt);
            portBytes_q <= cfgPort;
            elemBytes_q <= cfgElem;
            // [RULE1] [RULE3] [RULE12] pack only when narrower
            packActive_q <= params_q[`DSPP_PACK_BIT] && cfgElem < cfgPort;
            packBytes_q <= (params_q[`DSPP_PACK_BIT] && cfgElem < cfgPort) ? cfgPort : cfgElem;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Transfer engine
    // [RULE10] protected peripheral window
    assign protHit = srcSel_q == dspp_pkg::DSPP_SRC_PERIPH && addr_q >= `DSPP_PROT_LO && addr_q <= `DSPP_PROT_HI;
    assign elemMask = elemBytes_q == 3'h1 ? 32'h000000FF : (elemBytes_q == 3'h2 ? 32'h0000FFFF : 32'hFFFFFFFF);
    assign accNext = acc_q | 32'((srcRspData & elemMask) << {fill_q[1:0], 3'b000});
    assign newFill = fill_q + elemBytes_q;
    assign lastDone = pushValid_q && fifoInReady && remain_q == 16'h0000;

    always_ff @(posedge clock) begin
        if (reset) begin
            state_q <= dspp_pkg::DSPP_IDLE;
            addr_q <= 16'h0000;
            remain_q <= 16'h0000;
            fill_q <= 3'h0;
            acc_q <= 32'h00000000;
            reqValid_q <= 1'b0;
            req_q <= '0;
            pushValid_q <= 1'b0;
            pushWord_q <= '0;
        end else begin
            case (state_q)
                dspp_pkg::DSPP_IDLE: begin
                    if (startOk) begin
                        addr_q <= srcAddrReg_q;
                        remain_q <= count_q;
                        fill_q <= 3'h0;
                        acc_q <= 32'h00000000;
                        state_q <= count_q == 16'h0000 ? dspp_pkg::DSPP_IDLE : dspp_pkg::DSPP_CHK;
                    end
                end
                dspp_pkg::DSPP_CHK: begin
                    if (protHit) begin
                        state_q <= dspp_pkg::DSPP_IDLE;
                    end else begin
                        // [RULE6] [RULE7] [RULE8] one-hot port routing
                        req_q.portSel <= 4'h1 << srcSel_q;
                        req_q.addr <= addr_q;
                        req_q.size <= dtype_q;
                        reqValid_q <= 1'b1;
                        state_q <= dspp_pkg::DSPP_REQ;
                    end
                end
                dspp_pkg::DSPP_REQ: begin
                    if (srcReqReady) begin
                        reqValid_q <= 1'b0;
                        state_q <= dspp_pkg::DSPP_WAIT;
                    end
                end
                dspp_pkg::DSPP_WAIT: begin
                    if (srcRspValid) begin
                        addr_q <= addr_q + 16'(elemBytes_q);
                        remain_q <= remain_q - 16'h0001;
                        // [RULE2] [RULE4] push only a full word or the tail
                        if (newFill >= packBytes_q || remain_q == 16'h0001) begin
                            pushWord_q.bytes <= newFill;
                            pushWord_q.data <= accNext;
                            pushValid_q <= 1'b1;
                            fill_q <= 3'h0;
                            acc_q <= 32'h00000000;
                            state_q <= dspp_pkg::DSPP_PUSH;
                        end else begin
                            fill_q <= newFill;
                            acc_q <= accNext;
                            state_q <= dspp_pkg::DSPP_CHK;
                        end
                    end
                end
                dspp_pkg::DSPP_PUSH: begin
                    if (fifoInReady) begin
                        pushValid_q <= 1'b0;
                        state_q <= remain_q == 16'h0000 ? dspp_pkg::DSPP_IDLE : dspp_pkg::DSPP_CHK;
                    end
                end
                default: begin
                    state_q <= dspp_pkg::DSPP_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Sticky status, write one to clear, setting wins
    always_ff @(posedge clock) begin
        if (reset) begin
            done_q <= 1'b0;
            cfgErr_q <= 1'b0;
            protErr_q <= 1'b0;
        end else begin
            done_q <= lastDone || (startOk && count_q == 16'h0000) || (done_q && !(doWrite
                && {awAddr_q[7:2], 2'b00} == `DSPP_OFS_STATUS && wStrb_q[0] && wData_q[`DSPP_ST_DONE]));
            cfgErr_q <= (startPulse && state_q == dspp_pkg::DSPP_IDLE && startBad) || (cfgErr_q && !(doWrite
                && {awAddr_q[7:2], 2'b00} == `DSPP_OFS_STATUS && wStrb_q[0] && wData_q[`DSPP_ST_CFGERR]));
            protErr_q <= (state_q == dspp_pkg::DSPP_CHK && protHit) || (protErr_q && !(doWrite
                && {awAddr_q[7:2], 2'b00} == `DSPP_OFS_STATUS && wStrb_q[0] && wData_q[`DSPP_ST_PROTERR]));
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Buffer and registered stream output
    dspp_fifo #(
        .WIDTH($bits(dspp_pkg::dspp_word_t)),
        .DEPTH(`DSPP_FIFO_DEPTH)
    ) u_fifo (
        .clock(clock),
        .reset(reset),
        .inValid(pushValid_q),
        .inReady(fifoInReady),
        .inData(pushWord_q),
        .outValid(fifoOutValid),
        .outReady(fifoPop),
        .outData(fifoOut)
    );

    assign fifoPop = !outValid_q || outReady;

    always_ff @(posedge clock) begin
        if (reset) begin
            outValid_q <= 1'b0;
            outWord_q <= '0;
        end else if (fifoPop) begin
            outValid_q <= fifoOutValid;
            if (fifoOutValid) begin
                outWord_q <= fifoOut;
            end
        end
    end

    assign s_axi_awready = awReady_q;
    assign s_axi_wready = wReady_q;
    assign s_axi_bvalid = bValid_q;
    assign s_axi_bresp = bResp_q;
    assign s_axi_arready = arReady_q;
    assign s_axi_rvalid = rValid_q;
    assign s_axi_rdata = rData_q;
    assign s_axi_rresp = rResp_q;
    assign srcReq = req_q;
    assign srcReqValid = reqValid_q;
    assign outWord = outWord_q;
    assign outValid = outValid_q;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);

    property p_pack_on;
        startOk && params_q[`DSPP_PACK_BIT] && cfgDt == dspp_pkg::DSPP_DT_8 |=> packActive_q;
    endproperty
    a_pack_on: assert property (p_pack_on) else $error("pack bit ignored"); // [RULE1]
    property p_full_word;
        pushValid_q && packActive_q && remain_q != 16'h0000 |-> pushWord_q.bytes == portBytes_q;
    endproperty
    a_full_word: assert property (p_full_word) else $error("partial packed word"); // [RULE2]
    property p_no_pack;
        startOk && !params_q[`DSPP_PACK_BIT] |=> !packActive_q && packBytes_q == elemBytes_q;
    endproperty
    a_no_pack: assert property (p_no_pack) else $error("packed with bit clear"); // [RULE3]
    property p_push_stall;
        state_q == dspp_pkg::DSPP_PUSH |-> !reqValid_q && pushValid_q;
    endproperty
    a_push_stall: assert property (p_push_stall) else $error("read before push"); // [RULE4]
    property p_reserved;
        startPulse && state_q == dspp_pkg::DSPP_IDLE && cfgSrc > dspp_pkg::DSPP_SRC_PERIPH
            |=> cfgErr_q && state_q == dspp_pkg::DSPP_IDLE;
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved source started"); // [RULE5]
    property p_ram_route;
        reqValid_q && srcSel_q inside {dspp_pkg::DSPP_SRC_SINGLE_RAM, dspp_pkg::DSPP_SRC_DUAL_RAM}
            |-> req_q.portSel == (srcSel_q == dspp_pkg::DSPP_SRC_SINGLE_RAM ? 4'h1 : 4'h2);
    endproperty
    a_ram_route: assert property (p_ram_route) else $error("wrong RAM port"); // [RULE6]
    property p_ext_route;
        reqValid_q && srcSel_q == dspp_pkg::DSPP_SRC_EXT_MEM |-> req_q.portSel == 4'h4;
    endproperty
    a_ext_route: assert property (p_ext_route) else $error("wrong external port"); // [RULE7]
    property p_per_route;
        reqValid_q && srcSel_q == dspp_pkg::DSPP_SRC_PERIPH |-> req_q.portSel == 4'h8;
    endproperty
    a_per_route: assert property (p_per_route) else $error("wrong peripheral port"); // [RULE8]
    property p_protect;
        reqValid_q && req_q.portSel[3] |-> req_q.addr < `DSPP_PROT_LO;
    endproperty
    a_protect: assert property (p_protect) else $error("protected address read"); // [RULE10]
    property p_size;
        reqValid_q |-> req_q.size == dtype_q && dtype_q != 2'h3;
    endproperty
    a_size: assert property (p_size) else $error("bad access size"); // [RULE11]
    property p_equal;
        startOk && params_q[`DSPP_PACK_BIT] && cfgDt == dspp_pkg::DSPP_DT_32 |=> !packActive_q && packBytes_q == 3'h4;
    endproperty
    a_equal: assert property (p_equal) else $error("packing at equal width"); // [RULE12]

    c_packed: cover property (pushValid_q && fifoInReady && pushWord_q.bytes == 3'h4 && packActive_q);
    c_prot: cover property (state_q == dspp_pkg::DSPP_CHK && protHit);
    c_full: cover property (pushValid_q && !fifoInReady);
endmodule : dspp_source_pack
`default_nettype wire

/* File: common/dspp_defines.svh */
/*
 Constants of the DMA source port select and pack block: register byte
 offsets, field positions, reset values and fixed widths.
 Assumes inclusion by bare name from design files.
*/
// Overview of operation
// [RULE1] Bit 6 enables packing at the source
// [RULE2] Pack two or four elements into one word
// [RULE3] Pack bit clear: elements pass one by one
// [RULE4] Pack bit set: pack fully before transfer
// [RULE5] Bits 5-2 select source; other codes reserved
// [RULE6] Codes 0000b/0001b read single/dual access RAM
// [RULE7] Code 0010b reads external memory port
// [RULE8] Code 0011b reads via peripheral bus controller
// [RULE9] Software never pairs 8-bit with peripheral source
// [RULE10] Peripheral source cannot reach protected registers
// [RULE11] Data type 00b/01b/10b means 8/16/32 bits
// [RULE12] Pack at equal widths gives plain reads
`ifndef DSPP_DEFINES_SVH
`define DSPP_DEFINES_SVH

// Register byte offsets
`define DSPP_OFS_PARAMS 8'h00
`define DSPP_OFS_SRCADDR 8'h04
`define DSPP_OFS_COUNT 8'h08
`define DSPP_OFS_CTRL 8'h0C
`define DSPP_OFS_STATUS 8'h10

// Parameter register fields
`define DSPP_PACK_BIT 6
`define DSPP_SRC_MSB 5
`define DSPP_SRC_LSB 2
`define DSPP_DT_MSB 1
`define DSPP_DT_LSB 0

// Control and status fields
`define DSPP_CTRL_START 0
`define DSPP_ST_BUSY 0
`define DSPP_ST_DONE 1
`define DSPP_ST_CFGERR 2
`define DSPP_ST_PROTERR 3

// Reset values
`define DSPP_RST_PARAMS 16'h0000
`define DSPP_RST_SRCADDR 16'h0000
`define DSPP_RST_COUNT 16'h0000

// Port widths in bytes
`define DSPP_MEM_BYTES 3'h4
`define DSPP_PERIPH_BYTES 3'h2

// Peripheral addresses holding protected control registers
`define DSPP_PROT_LO 16'hFC00
`define DSPP_PROT_HI 16'hFFFF

// Bus answers and buffer
`define DSPP_RESP_OKAY 2'h0
`define DSPP_RESP_SLVERR 2'h2
`define DSPP_FIFO_DEPTH 4

`endif

/* File: common/dspp_pkg.sv */
/*
 Types of the DMA source port select and pack block.
 Assumes nothing of its surroundings.
*/
`default_nettype none
package dspp_pkg;

    typedef enum logic [2:0] {
        DSPP_IDLE = 3'h0,
        DSPP_CHK = 3'h1,
        DSPP_REQ = 3'h3,
        DSPP_WAIT = 3'h2,
        DSPP_PUSH = 3'h6
    } dspp_state_t;

    typedef enum logic [3:0] {
        DSPP_SRC_SINGLE_RAM = 4'h0,
        DSPP_SRC_DUAL_RAM = 4'h1,
        DSPP_SRC_EXT_MEM = 4'h2,
        DSPP_SRC_PERIPH = 4'h3
    } dspp_src_t;

    typedef enum logic [1:0] {
        DSPP_DT_8 = 2'h0,
        DSPP_DT_16 = 2'h1,
        DSPP_DT_32 = 2'h2
    } dspp_dtype_t;

    typedef struct packed {
        logic [2:0] bytes;
        logic [31:0] data;
    } dspp_word_t;

    typedef struct packed {
        logic [3:0] portSel;
        logic [15:0] addr;
        logic [1:0] size;
    } dspp_req_t;

endpackage : dspp_pkg
`default_nettype wire

/* File: rtl/dspp_fifo.sv */
/*
 Small FIFO with valid and ready on both sides.
 Assumes a power-of-two depth and a single clock.
*/
`timescale 1ns/10ps
`default_nettype none
`include "dspp_defines.svh"
module dspp_fifo #(
    parameter int WIDTH = 35,
    parameter int DEPTH = `DSPP_FIFO_DEPTH
) (
    input wire logic clock,
    input wire logic reset,
    input wire logic inValid,
    output logic inReady,
    input wire logic [WIDTH-1:0] inData,
    output logic outValid,
    input wire logic outReady,
    output logic [WIDTH-1:0] outData
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wrPtr_q;
    logic [AW-1:0] rdPtr_q;
    logic [AW:0] count_q;
    logic push;
    logic pop;

    assign inReady = count_q != (AW + 1)'(DEPTH);
    assign outValid = count_q != '0;
    assign outData = mem[rdPtr_q];
    assign push = inValid && inReady;
    assign pop = outValid && outReady;

    for (genvar i = 0; i < DEPTH; i++) begin : g_entry
        always_ff @(posedge clock) begin
            if (push && wrPtr_q == AW'(i)) begin
                mem[i] <= inData;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            wrPtr_q <= '0;
            rdPtr_q <= '0;
            count_q <= '0;
        end else begin
            wrPtr_q <= wrPtr_q + AW'(push);
            rdPtr_q <= rdPtr_q + AW'(pop);
            count_q <= count_q + (AW + 1)'(push) - (AW + 1)'(pop);
        end
    end
endmodule : dspp_fifo
`default_nettype wire

/* File: tb/dspp_src_model.sv */
/* Source port model: on-chip memories, external port, peripheral bus.
 Assumes the block's clock and reset. */
`timescale 1ns/10ps
`default_nettype none
module dspp_src_model (
    input wire logic clock,
    input wire logic reset,
    input wire logic slow,
    input wire dspp_pkg::dspp_req_t srcReq,
    input wire logic srcReqValid,
    output logic srcReqReady,
    output logic srcRspValid,
    output logic [31:0] srcRspData
);
    logic phase, busy;
    logic [7:0] a;
    logic [31:0] mask;
    always_ff @(posedge clock) begin
        phase <= !phase;
        srcRspValid <= 1'b0;
        srcRspData <= ~srcRspData;
        if (reset) begin
            phase <= 1'b0;
            busy <= 1'b0;
            srcReqReady <= 1'b0;
        end else if (busy) begin
            busy <= slow && phase;
            srcRspValid <= !(slow && phase);
            srcRspData <= mask & ({a + 8'h3, a + 8'h2, a + 8'h1, a} ^ 32'h5A5A5A5A);
        end else if (srcReqValid && srcReqReady) begin
            busy <= 1'b1;
            srcReqReady <= 1'b0;
            a <= srcReq.addr[7:0];
            mask <= srcReq.size == 2'h0 ? 32'h000000FF : srcReq.size == 2'h1 ? 32'h0000FFFF : 32'hFFFFFFFF;
        end else begin
            srcReqReady <= !(slow && phase);
        end
    end
endmodule : dspp_src_model
`default_nettype wire

/* File: tb/testbench.sv */
/* Bench of the DMA source port block.
 Assumes the source port model and a 100 MHz clock. */
`timescale 1ns/10ps
`default_nettype none
module testbench;
    logic clock, reset, slow, outReady, outValid, srcReqValid, srcReqReady, srcRspValid;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, srcRspData;
    logic [3:0] s_axi_wstrb, src;
    logic [3:0] tick = 4'h0;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    int miscompares = 0, checks_done = 0, reqs;
    dspp_pkg::dspp_req_t srcReq;
    dspp_pkg::dspp_word_t outWord, seen[$], want[$];
    dspp_source_pack dspp_source_pack_inst (.*);
    dspp_src_model dspp_src_model_inst (.*);
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    always @(posedge clock) begin
        tick <= tick + 4'h1;
        outReady <= tick[3] & tick[2];
        if (outValid && outReady)
            seen.push_back(outWord);
        if (srcReqValid && srcReqReady) begin
            reqs++;
            check(srcReq.portSel, 4'h1 << src); // port per code
        end
    end
    task automatic check(input logic [63:0] got, input logic [63:0] exp);
        checks_done++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected at %0t: got %0h want %0h", $time, got, exp);
        end
    endtask : check
    task automatic finish_test();
        if (miscompares == 0 && checks_done > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : finish_test
    task automatic axi(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [33:0] q);
        @(posedge clock);
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} <= {a, a, d};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {3{wr}};
        {s_axi_arvalid, s_axi_rready} <= {2{!wr}};
        do begin
            @(posedge clock);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while ((wr ? s_axi_bvalid : s_axi_rvalid) !== 1'b1);
        q = wr ? {s_axi_bresp, 32'h0} : {s_axi_rresp, s_axi_rdata};
        {s_axi_bready, s_axi_rready} <= 2'b00;
    endtask : axi
    task automatic run(input logic [3:0] s, input logic [1:0] dt, input logic pk, input logic [15:0] ad,
            input logic [15:0] n, input logic [1:0] err);
        int eb, per, k;
        logic [33:0] q;
        dspp_pkg::dspp_word_t w;
        eb = 1 << dt;
        per = s == 4'h3 ? 2 : 4;
        per = (pk && eb < per) ? per / eb : 1;
        src = s;
        reqs = 0;
        k = 0;
        w = '0;
        seen.delete();
        want.delete();
        for (int i = 0; i < n && err == 2'h0; i++) begin
            for (int j = 0; j < eb; j++)
                w.data[8 * (k * eb + j) +: 8] = 8'(ad + i * eb + j) ^ 8'h5A;
            w.bytes += 3'(eb);
            k++;
            if (k == per || i == n - 1) begin
                want.push_back(w);
                k = 0;
                w = '0;
            end
        end
        axi(1'b1, 8'h00, {25'h0, pk, s, dt}, q);
        axi(1'b1, 8'h04, {16'h0, ad}, q);
        axi(1'b1, 8'h08, {16'h0, n}, q);
        axi(1'b1, 8'h0C, 32'h1, q);
        do axi(1'b0, 8'h10, 32'h0, q); while (q[0] !== 1'b0);
        while (seen.size() < want.size()) @(posedge clock);
        check(q[3:2], err); // error flags
        check(reqs, err == 2'h0 ? n : 0); // no blocked reads
        check(seen.size(), want.size()); // word count
        foreach (want[i]) check(seen[i], want[i]); // word contents
        axi(1'b1, 8'h10, 32'hE, q);
    endtask : run
    initial begin
        logic [33:0] q;
        {reset, slow, src, s_axi_wstrb} = {2'b10, 8'hF};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
        repeat (16) @(posedge clock);
        reset <= 1'b0;
        @(posedge clock);
        axi(1'b0, 8'h00, 32'h0, q);
        check(q, 34'h0); // parameter reset
        axi(1'b0, 8'h3C, 32'h0, q);
        check(q[33:32], 2'h2);
        axi(1'b1, 8'h3C, 32'h0, q);
        check(q[33:32], 2'h2);
        for (int s = 0; s < 4; s++)
            run(4'(s), 2'h1, 1'b0, 16'h0100, 16'h3, 2'h0); // each port
        slow <= 1'b1;
        run(4'h0, 2'h0, 1'b1, 16'h0011, 16'h9, 2'h0); // bytes packed
        run(4'h3, 2'h1, 1'b1, 16'h0200, 16'h3, 2'h0); // equal width
        slow <= 1'b0;
        run(4'h2, 2'h2, 1'b1, 16'h0400, 16'h2, 2'h0); // full words
        run(4'h1, 2'h1, 1'b1, 16'h0020, 16'h5, 2'h0); // halves packed
        run(4'h1, 2'h0, 1'b0, 16'h0007, 16'hC, 2'h0); // bytes unpacked
        run(4'h4, 2'h1, 1'b0, 16'h0100, 16'h2, 2'h1); // reserved code
        run(4'h3, 2'h0, 1'b0, 16'h0100, 16'h2, 2'h1); // bytes on peripheral
        run(4'h3, 2'h1, 1'b1, 16'hFC00, 16'h2, 2'h2); // blocked window
        finish_test();
    end
    initial begin
        #300000;
        miscompares++;
        finish_test();
    end
endmodule : testbench
`default_nettype wire
